/* File: shared/hc_misc_pkg.sv */
// register indices, field positions and reset values of the host misc and buffer register slice
package hc_misc_pkg;

	// register indices; the byte address on the bus is four times the index
	localparam logic [7:0] IDX_IRQ_MASK_RD     = 8'h25;
	localparam logic [7:0] IDX_IRQ_MASK_WR     = 8'ha5;
	localparam logic [7:0] IDX_IDENTITY_RD     = 8'h27;
	localparam logic [7:0] IDX_SCRATCH_RD      = 8'h28;
	localparam logic [7:0] IDX_SCRATCH_WR      = 8'ha8;
	localparam logic [7:0] IDX_SOFT_RESET_WR   = 8'ha9;
	localparam logic [7:0] IDX_BUF_STATUS_RD   = 8'h2c;
	localparam logic [7:0] IDX_BUF_STATUS_WR   = 8'hac;

	// apb address geometry
	localparam int         ADDR_W              = 12;
	localparam int         DATA_W              = 32;
	localparam int         REG_W               = 16;
	localparam int         IDX_LSB             = 2;

	// interrupt enable mask fields
	localparam int         IRQ_SRC_N           = 10;
	localparam int         FRAME_START_BIT     = 0;
	localparam int         ISO_LIST_A_BIT      = 1;
	localparam int         ISO_LIST_B_BIT      = 2;
	localparam int         END_OF_TRANSFER_BIT = 3;
	localparam int         OPERATIONAL_BIT     = 4;
	localparam int         SUSPENDED_BIT       = 5;
	localparam int         CLOCK_OK_BIT        = 6;
	localparam int         PERIODIC_LIST_BIT   = 7;
	localparam int         ASYNC_LIST_BIT      = 8;
	localparam int         DUAL_ROLE_BIT       = 9;
	localparam logic [9:0] IRQ_MASK_RESET      = 10'h000;

	// buffer status fields
	localparam int         ISO_A_FULL_BIT      = 0;
	localparam int         ISO_B_FULL_BIT      = 1;
	localparam int         PERIODIC_RUN_BIT    = 2;
	localparam int         ASYNC_RUN_BIT       = 3;
	localparam int         CLEAR_HALF_BIT      = 4;
	localparam int         ISO_A_IN_USE_BIT    = 5;
	localparam int         ISO_B_IN_USE_BIT    = 6;
	localparam int         ISO_A_DONE_BIT      = 8;
	localparam int         ISO_B_DONE_BIT      = 9;
	localparam int         HALF_BIT            = 10;
	localparam int         BUF_CTRL_W          = 5;
	localparam logic [4:0] BUF_CTRL_RESET      = 5'h00;

	// scratch and software reset
	localparam logic [15:0] SCRATCH_RESET      = 16'h0000;
	localparam logic [15:0] SOFT_RESET_KEY     = 16'h00f6;

	// identity word; both bytes are arbitrary neutral values
	localparam logic [7:0] PRODUCT_CODE        = 8'h5a;
	localparam logic [7:0] REVISION_CODE       = 8'h01;

endpackage

/* File: hdl/status_flag.sv */
// sticky status flag set by hardware, cleared by software; set wins
`timescale 1ns/10ps
module status_flag (
	// clock and reset
	input  wire logic mclk_in,
	input  wire logic rst_n_in,
	// control
	input  wire logic set_in,
	input  wire logic clr_in,
	// state
	output logic      flag_out
);

	logic flag_q;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flag_q <= 1'b0;
		end else if (set_in) begin
			flag_q <= 1'b1;
		end else if (clr_in) begin
			flag_q <= 1'b0;
		end
	end

	assign flag_out = flag_q;

endmodule

/* File: hdl/half_indicator.sv */
// paired entry half indicator: flips on hardware event, cleared by software request
`timescale 1ns/10ps
module half_indicator (
	// clock and reset
	input  wire logic mclk_in,
	input  wire logic rst_n_in,
	// control
	input  wire logic flip_in,
	input  wire logic clr_in,
	// state
	output logic      half_out
);

	logic half_q;

	// a flip landing with a clear is not lost: clear first, then flip
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			half_q <= 1'b0;
		end else if (clr_in) begin
			half_q <= flip_in;
		end else if (flip_in) begin
			half_q <= ~half_q;
		end
	end

	assign half_out = half_q;

endmodule

/* File: hdl/hc_misc_regs.sv */
// host controller misc and buffer status registers behind an apb slave
//
// Behaviour
// - mask bit 9 resets 0; when set, dual-role source may raise interrupt.
// - mask bit 8 resets 0; when set, async list source may raise interrupt.
// - mask bit 7 resets 0; when set, periodic list source may raise interrupt.
// - mask bit 6 resets 0; when set, clock-ready event may raise interrupt.
// - mask bit 5 resets 0; when set, suspended event may raise interrupt.
// - mask bit 4 resets 0; when set, operational group may raise interrupt.
// - mask bit 3 resets 0; when set, end-of-transfer may raise interrupt.
// - mask bit 2 resets 0; when set, second iso buffer completion may interrupt.
// - mask bit 1 resets 0; when set, first iso buffer completion may interrupt.
// - mask bit 0 resets 0; when set, frame start may interrupt; 15..10 reserved.
// - read-only identity word at 27h: product byte high, revision byte low.
// - 16-bit scratch, read 28h, written A8h, resets 0000h, no side effect.
// - writing F6h to A9h resets all controller registers, buffer memory kept.
// - buffer status read at 2Ch, written at ACh, holds status fields.
// - software sets full and run bits to make the controller process buffers.
// - bit 4 rising write clears half indicator only while async run is 0.
// - bits 9,8 show iso buffer read; bit 10 shows active paired half.
// - bits 6,5 show second or first iso buffer being accessed.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
module hc_misc_regs
	import hc_misc_pkg::*;
(
	// clock and reset
	input  wire logic                 mclk_in,
	input  wire logic                 rst_n_in,
	// apb slave
	input  wire logic                 psel_in,
	input  wire logic                 penable_in,
	input  wire logic                 pwrite_in,
	input  wire logic [ADDR_W-1:0]    paddr_in,
	input  wire logic [DATA_W-1:0]    pwdata_in,
	output logic                      pready_out,
	output logic      [DATA_W-1:0]    prdata_out,
	output logic                      pslverr_out,
	// interrupt sources from the controller core
	input  wire logic [IRQ_SRC_N-1:0] irq_src_in,
	// interrupt request towards the pin logic
	output logic                      irq_req_out,
	output logic      [IRQ_SRC_N-1:0] irq_pending_out,
	// buffer engine status
	input  wire logic                 iso_a_read_in,
	input  wire logic                 iso_b_read_in,
	input  wire logic                 iso_a_in_use_in,
	input  wire logic                 iso_b_in_use_in,
	input  wire logic                 half_flip_in,
	// buffer engine control
	output logic                      iso_a_full_out,
	output logic                      iso_b_full_out,
	output logic                      periodic_list_run_out,
	output logic                      async_list_run_out,
	output logic                      paired_entry_half_out,
	// software reset towards the other controller registers
	output logic                      soft_reset_out
);

	// bus decode
	logic [ADDR_W-IDX_LSB-1:0] idx;
	logic [7:0]                idx8;
	logic                      word_ok;
	logic                      setup_ph;
	logic                      wr_en;
	logic                      rd_known;
	logic                      wr_known;
	logic [REG_W-1:0]          wdata16;

	// register state
	logic [IRQ_SRC_N-1:0]      irq_mask_q;
	logic [REG_W-1:0]          scratch_q;
	logic [BUF_CTRL_W-1:0]     buf_ctrl_q;
	logic                      soft_reset_q;
	logic                      irq_req_q;
	logic [IRQ_SRC_N-1:0]      irq_pending_q;
	logic [DATA_W-1:0]         prdata_q;
	logic                      pslverr_q;

	// derived
	logic                      soft_hit;
	logic                      buf_wr;
	logic                      half_clr;
	logic                      iso_a_done;
	logic                      iso_b_done;
	logic                      half_now;
	logic [IRQ_SRC_N-1:0]      gated_src;
	logic [REG_W-1:0]          buf_status;
	logic [REG_W-1:0]          rd_word;
	logic [BUF_CTRL_W-1:0]     ctrl_wr;
	logic                      acc_ph;
	logic                      mask_wr;
	logic                      scratch_wr;
	logic                      key_wr;
	logic                      iso_a_rearm;
	logic                      iso_b_rearm;
	logic [REG_W-1:0]          rd_data16;

	assign idx      = paddr_in[ADDR_W-1:IDX_LSB];
	assign idx8     = idx[7:0];
	assign word_ok  = (paddr_in[IDX_LSB-1:0] == 2'b00) && (idx[ADDR_W-IDX_LSB-1:8] == '0);
	assign setup_ph = psel_in && !penable_in;
	// zero wait states: every access phase completes in its first cycle
	assign acc_ph   = psel_in && penable_in;
	assign wr_en    = acc_ph && pwrite_in;
	assign wdata16  = pwdata_in[REG_W-1:0];
	assign ctrl_wr  = wdata16[BUF_CTRL_W-1:0];

	// per-register strobes; all need an aligned word in the access phase,
	// so a refused write leaves every register as it was
	assign mask_wr    = wr_en && word_ok && (idx8 == IDX_IRQ_MASK_WR);
	assign scratch_wr = wr_en && word_ok && (idx8 == IDX_SCRATCH_WR);
	assign key_wr     = wr_en && word_ok && (idx8 == IDX_SOFT_RESET_WR);

	// only a 0-to-1 write of a full bit rearms its done flag; rewriting 1 keeps the report
	assign iso_a_rearm = buf_wr && ctrl_wr[ISO_A_FULL_BIT] && !buf_ctrl_q[ISO_A_FULL_BIT];
	assign iso_b_rearm = buf_wr && ctrl_wr[ISO_B_FULL_BIT] && !buf_ctrl_q[ISO_B_FULL_BIT];

	// which indices answer a read and which a write
	always_comb begin
		rd_known = 1'b0;
		wr_known = 1'b0;
		if (word_ok) begin
			case (idx8)
				IDX_IRQ_MASK_RD: begin
					rd_known = 1'b1;
				end
				IDX_IDENTITY_RD: begin
					rd_known = 1'b1;
				end
				IDX_SCRATCH_RD: begin
					rd_known = 1'b1;
				end
				IDX_BUF_STATUS_RD: begin
					rd_known = 1'b1;
				end
				IDX_SOFT_RESET_WR: begin
					rd_known = 1'b1;
					wr_known = 1'b1;
				end
				IDX_IRQ_MASK_WR: begin
					wr_known = 1'b1;
				end
				IDX_SCRATCH_WR: begin
					wr_known = 1'b1;
				end
				IDX_BUF_STATUS_WR: begin
					wr_known = 1'b1;
				end
				default: begin
					rd_known = 1'b0;
					wr_known = 1'b0;
				end
			endcase
		end
	end

	// software reset: only the exact key counts, anything else is dropped
	assign soft_hit = key_wr && (wdata16 == SOFT_RESET_KEY);

	// buffer status write strobe
	assign buf_wr = wr_en && word_ok && (idx8 == IDX_BUF_STATUS_WR);

	// rising write of the clear bit, gated by the async run bit held before this write
	assign half_clr = buf_wr && ctrl_wr[CLEAR_HALF_BIT] && !buf_ctrl_q[CLEAR_HALF_BIT]
		&& !buf_ctrl_q[ASYNC_RUN_BIT];

	// interrupt enable mask
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_mask_q <= IRQ_MASK_RESET;
		end else if (soft_hit) begin
			irq_mask_q <= IRQ_MASK_RESET;
		end else if (mask_wr) begin
			irq_mask_q <= wdata16[IRQ_SRC_N-1:0];
		end
	end

	// per-source gating; reserved mask bits 15..10 are not stored
	assign gated_src[DUAL_ROLE_BIT]       = irq_src_in[DUAL_ROLE_BIT] & irq_mask_q[DUAL_ROLE_BIT];
	assign gated_src[ASYNC_LIST_BIT]      = irq_src_in[ASYNC_LIST_BIT] & irq_mask_q[ASYNC_LIST_BIT];
	assign gated_src[PERIODIC_LIST_BIT]   = irq_src_in[PERIODIC_LIST_BIT] & irq_mask_q[PERIODIC_LIST_BIT];
	assign gated_src[CLOCK_OK_BIT]        = irq_src_in[CLOCK_OK_BIT] & irq_mask_q[CLOCK_OK_BIT];
	assign gated_src[SUSPENDED_BIT]       = irq_src_in[SUSPENDED_BIT] & irq_mask_q[SUSPENDED_BIT];
	assign gated_src[OPERATIONAL_BIT]     = irq_src_in[OPERATIONAL_BIT] & irq_mask_q[OPERATIONAL_BIT];
	assign gated_src[END_OF_TRANSFER_BIT] = irq_src_in[END_OF_TRANSFER_BIT] & irq_mask_q[END_OF_TRANSFER_BIT];
	assign gated_src[ISO_LIST_B_BIT]      = irq_src_in[ISO_LIST_B_BIT] & irq_mask_q[ISO_LIST_B_BIT];
	assign gated_src[ISO_LIST_A_BIT]      = irq_src_in[ISO_LIST_A_BIT] & irq_mask_q[ISO_LIST_A_BIT];
	assign gated_src[FRAME_START_BIT]     = irq_src_in[FRAME_START_BIT] & irq_mask_q[FRAME_START_BIT];

	// registered request so the pin logic sees a glitch-free level; the key clears it at once
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_req_q <= 1'b0;
		end else if (soft_hit) begin
			irq_req_q <= 1'b0;
		end else begin
			irq_req_q <= |gated_src;
		end
	end

	// per-source pending copy, cleared together with the mask by the key
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_pending_q <= '0;
		end else if (soft_hit) begin
			irq_pending_q <= '0;
		end else begin
			irq_pending_q <= gated_src;
		end
	end

	// scratch storage, no side effect on anything else
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			scratch_q <= SCRATCH_RESET;
		end else if (soft_hit) begin
			scratch_q <= SCRATCH_RESET;
		end else if (scratch_wr) begin
			scratch_q <= wdata16;
		end
	end

	// writable buffer control bits 4..0
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			buf_ctrl_q <= BUF_CTRL_RESET;
		end else if (soft_hit) begin
			buf_ctrl_q <= BUF_CTRL_RESET;
		end else if (buf_wr) begin
			buf_ctrl_q <= ctrl_wr;
		end
	end

	// done flags: a new full request clears the old done, a controller read sets it
	status_flag iso_a_done_flag (
		.mclk_in  (mclk_in),
		.rst_n_in (rst_n_in),
		.set_in   (iso_a_read_in),
		.clr_in   (soft_hit || iso_a_rearm),
		.flag_out (iso_a_done)
	);

	status_flag iso_b_done_flag (
		.mclk_in  (mclk_in),
		.rst_n_in (rst_n_in),
		.set_in   (iso_b_read_in),
		.clr_in   (soft_hit || iso_b_rearm),
		.flag_out (iso_b_done)
	);

	// paired entry half indicator
	half_indicator paired_half (
		.mclk_in  (mclk_in),
		.rst_n_in (rst_n_in),
		.flip_in  (half_flip_in),
		.clr_in   (half_clr || soft_hit),
		.half_out (half_now)
	);

	// status word; reserved bits 15..11 and 7 read zero
	always_comb begin
		buf_status                   = '0;
		buf_status[BUF_CTRL_W-1:0]   = buf_ctrl_q;
		buf_status[ISO_A_IN_USE_BIT] = iso_a_in_use_in;
		buf_status[ISO_B_IN_USE_BIT] = iso_b_in_use_in;
		buf_status[ISO_A_DONE_BIT]   = iso_a_done;
		buf_status[ISO_B_DONE_BIT]   = iso_b_done;
		buf_status[HALF_BIT]         = half_now;
	end

	// read multiplexer
	always_comb begin
		rd_word = '0;
		case (idx8)
			IDX_IRQ_MASK_RD: begin
				rd_word[IRQ_SRC_N-1:0] = irq_mask_q;
			end
			IDX_IDENTITY_RD: begin
				rd_word = {PRODUCT_CODE, REVISION_CODE};
			end
			IDX_SCRATCH_RD: begin
				rd_word = scratch_q;
			end
			IDX_BUF_STATUS_RD: begin
				rd_word = buf_status;
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	// unmapped reads answer zero beside the error
	assign rd_data16 = rd_known ? rd_word : {REG_W{1'b0}};

	// read data is captured in the setup cycle so it comes from a flop
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prdata_q <= '0;
		end else if (setup_ph && !pwrite_in) begin
			prdata_q <= {{(DATA_W-REG_W){1'b0}}, rd_data16};
		end else if (setup_ph || !psel_in) begin
			prdata_q <= '0;
		end
	end

	// error for the coming access phase; a refused access touches no register
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pslverr_q <= 1'b0;
		end else if (setup_ph) begin
			pslverr_q <= pwrite_in ? !wr_known : !rd_known;
		end else if (!psel_in) begin
			pslverr_q <= 1'b0;
		end
	end

	// one-cycle reset pulse to the rest of the controller; buffer memory is never touched here
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			soft_reset_q <= 1'b0;
		end else begin
			soft_reset_q <= soft_hit;
		end
	end

	// outputs
	assign pready_out            = 1'b1;
	assign prdata_out            = prdata_q;
	assign pslverr_out           = pslverr_q && acc_ph;
	assign irq_req_out           = irq_req_q;
	assign irq_pending_out       = irq_pending_q;
	assign iso_a_full_out        = buf_ctrl_q[ISO_A_FULL_BIT];
	assign iso_b_full_out        = buf_ctrl_q[ISO_B_FULL_BIT];
	assign periodic_list_run_out = buf_ctrl_q[PERIODIC_RUN_BIT];
	assign async_list_run_out    = buf_ctrl_q[ASYNC_RUN_BIT];
	assign paired_entry_half_out = half_now;
	assign soft_reset_out        = soft_reset_q;

endmodule

/* File: sim/hc_core_model.sv */
// behavioural model of the controller core that feeds the register slice
`timescale 1ns/10ps
module hc_core_model (
	// clock
	input	wire logic		mclk_in,
	// control from the register slice
	input	wire logic		iso_a_full_out,
	input	wire logic		iso_b_full_out,
	input	wire logic		async_list_run_out,
	// status towards the register slice
	output	logic [9:0]		irq_src_in,
	output	logic			iso_a_read_in,
	output	logic			iso_b_read_in,
	output	logic			iso_a_in_use_in,
	output	logic			iso_b_in_use_in,
	output	logic			half_flip_in
);
	initial begin
		irq_src_in = 10'h000;
		{iso_a_read_in, iso_b_read_in, iso_a_in_use_in, iso_b_in_use_in, half_flip_in} = 5'h00;
	end
	task automatic raise(input logic [9:0] v);
		@(posedge mclk_in);
		irq_src_in <= v;
	endtask
	// a buffer is only read once software has marked it full
	task automatic read_buf(input logic b);
		@(posedge mclk_in);
		iso_a_read_in <= !b && iso_a_full_out;
		iso_b_read_in <= b && iso_b_full_out;
		@(posedge mclk_in);
		iso_a_read_in <= 1'b0;
		iso_b_read_in <= 1'b0;
	endtask
	task automatic use_buf(input logic a, input logic b);
		@(posedge mclk_in);
		iso_a_in_use_in <= a;
		iso_b_in_use_in <= b;
	endtask
	// paired entries only alternate while the async list runs
	task automatic flip();
		@(posedge mclk_in);
		half_flip_in <= async_list_run_out;
		@(posedge mclk_in);
		half_flip_in <= 1'b0;
	endtask
endmodule

/* File: sim/hc_misc_regs_asserts.sv */
// concurrent checks on the ports of the misc and buffer register slice
`timescale 1ns/10ps
module hc_misc_regs_asserts
	import hc_misc_pkg::*;
(
	// clock and reset
	input	wire logic			mclk_in,
	input	wire logic			rst_n_in,
	// apb
	input	wire logic			psel_in,
	input	wire logic			penable_in,
	input	wire logic			pwrite_in,
	input	wire logic [ADDR_W-1:0]		paddr_in,
	input	wire logic [DATA_W-1:0]		pwdata_in,
	input	wire logic [DATA_W-1:0]		prdata_out,
	input	wire logic			pslverr_out,
	// interrupt
	input	wire logic [IRQ_SRC_N-1:0]	irq_src_in,
	input	wire logic			irq_req_out,
	input	wire logic [IRQ_SRC_N-1:0]	irq_pending_out,
	// buffer engine
	input	wire logic			iso_a_in_use_in,
	input	wire logic			iso_b_in_use_in,
	input	wire logic			half_flip_in,
	input	wire logic			iso_a_full_out,
	input	wire logic			iso_b_full_out,
	input	wire logic			periodic_list_run_out,
	input	wire logic			async_list_run_out,
	input	wire logic			paired_entry_half_out,
	input	wire logic			soft_reset_out
);
	logic		acc, wr_bsw, wr_key, rd_key, rd_id, rd_bsr;
	logic [3:0]	run;
	assign acc = psel_in & penable_in;
	assign wr_bsw = acc & pwrite_in & (paddr_in == {2'b00, IDX_BUF_STATUS_WR, 2'b00});
	assign wr_key = acc & pwrite_in & (paddr_in == {2'b00, IDX_SOFT_RESET_WR, 2'b00});
	assign rd_key = acc & !pwrite_in & (paddr_in == {2'b00, IDX_SOFT_RESET_WR, 2'b00});
	assign rd_id = acc & !pwrite_in & (paddr_in == {2'b00, IDX_IDENTITY_RD, 2'b00});
	assign rd_bsr = acc & !pwrite_in & (paddr_in == {2'b00, IDX_BUF_STATUS_RD, 2'b00});
	assign run = {async_list_run_out, periodic_list_run_out, iso_b_full_out, iso_a_full_out};
	default clocking dc @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	irq_subset_a: assert property ((irq_pending_out & ~$past(irq_src_in)) == '0)
		else $error("pending bit without its source");
	irq_req_or_a: assert property (irq_req_out == |irq_pending_out)
		else $error("request differs from pending");
	key_pulse_a: assert property (wr_key && pwdata_in[15:0] == SOFT_RESET_KEY |=> soft_reset_out ##1 !soft_reset_out)
		else $error("reset pulse wrong");
	key_clears_a: assert property (soft_reset_out |-> run == 4'h0 && !paired_entry_half_out
		&& !irq_req_out && irq_pending_out == '0)
		else $error("controls not cleared by reset");
	bad_key_a: assert property (wr_key && pwdata_in[15:0] != SOFT_RESET_KEY |=> !soft_reset_out)
		else $error("wrong key acted");
	key_read_a: assert property (rd_key |-> prdata_out == '0 && !pslverr_out)
		else $error("reset code read not zero");
	run_follows_a: assert property (wr_bsw |=> run == $past(pwdata_in[3:0]))
		else $error("control bits not written");
	run_hold_a: assert property (!$past(wr_bsw) && !soft_reset_out |-> $stable(run))
		else $error("control bits moved");
	half_gate_a: assert property (wr_bsw && async_list_run_out && !half_flip_in |=> $stable(paired_entry_half_out))
		else $error("half cleared while running");
	id_read_a: assert property (rd_id |-> prdata_out == {16'h0000, PRODUCT_CODE, REVISION_CODE} && !pslverr_out)
		else $error("identity wrong");
	status_read_a: assert property (rd_bsr |-> prdata_out[6:5] == $past({iso_b_in_use_in, iso_a_in_use_in})
		&& prdata_out[10] == $past(paired_entry_half_out) && prdata_out[3:0] == $past(run)
		&& {prdata_out[31:11], prdata_out[7]} == '0)
		else $error("status word wrong");

	cover property (wr_key && pwdata_in[15:0] == SOFT_RESET_KEY);
	cover property (rd_bsr && prdata_out[10]);
	cover property (wr_bsw && async_list_run_out && pwdata_in[4]);
endmodule
bind hc_misc_regs hc_misc_regs_asserts chk (.*);

/* File: sim/testbench.sv */
// self-checking bench for the misc and buffer register slice
`timescale 1ns/10ps
module testbench
	import hc_misc_pkg::*;
;
	logic			mclk_in = 1'b0;
	logic			rst_n_in = 1'b0;
	logic			psel_in = 1'b0;
	logic			penable_in = 1'b0;
	logic			pwrite_in;
	logic [ADDR_W-1:0]	paddr_in;
	logic [DATA_W-1:0]	pwdata_in;
	logic [DATA_W-1:0]	prdata_out;
	logic [IRQ_SRC_N-1:0]	irq_src_in, irq_pending_out;
	logic			pready_out, pslverr_out, irq_req_out, soft_reset_out, paired_entry_half_out;
	logic			iso_a_read_in, iso_b_read_in, iso_a_in_use_in, iso_b_in_use_in, half_flip_in;
	logic			iso_a_full_out, iso_b_full_out, periodic_list_run_out, async_list_run_out;
	int			n_fail = 0;
	int			checks_done = 0;
	logic [31:0]		rd;
	logic			err;

	always #5 mclk_in = ~mclk_in;
	hc_misc_regs dut (.*);
	hc_core_model core (.*);

	function automatic logic [11:0] adr(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// the slave answers at once, yet the wait stays bounded
	task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] wd);
		int n = 0;
		@(posedge mclk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= {16'h0000, wd};
		@(posedge mclk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge mclk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 16);
		if (n >= 16) begin
			n_fail++;
			tally_and_finish();
		end
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, adr(idx), 16'h0000);
		check(what, exp, rd);
		check("error flag", 32'h0, {31'h0, err});
	endtask
	task automatic err_chk(input logic wr, input logic [11:0] a);
		apb(wr, a, 16'hffff);
		check("refused", 32'h1, {31'h0, err});
	endtask
	task automatic settle();
		repeat (2) @(posedge mclk_in);
		#1;
	endtask

	initial begin
		repeat (2) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		rd_chk("mask reset", IDX_IRQ_MASK_RD, 32'h0);
		rd_chk("identity", IDX_IDENTITY_RD, {16'h0000, PRODUCT_CODE, REVISION_CODE});
		rd_chk("scratch reset", IDX_SCRATCH_RD, 32'h0);
		rd_chk("status reset", IDX_BUF_STATUS_RD, 32'h0);
		rd_chk("reset code read", IDX_SOFT_RESET_WR, 32'h0);
		$display("test reset_values done");
		core.raise(10'h3ff);
		for (int i = 0; i < IRQ_SRC_N; i++) begin
			apb(1'b1, adr(IDX_IRQ_MASK_WR), 16'(1 << i));
			settle();
			check("pending", 32'(1 << i), {22'h0, irq_pending_out});
			check("request", 32'h1, {31'h0, irq_req_out});
		end
		apb(1'b1, adr(IDX_IRQ_MASK_WR), 16'hffff);
		rd_chk("mask reserved", IDX_IRQ_MASK_RD, 32'h3ff);
		core.raise(10'h000);
		settle();
		check("request idle", 32'h0, {31'h0, irq_req_out});
		$display("test irq_mask done");
		apb(1'b1, adr(IDX_SCRATCH_WR), 16'ha5c3);
		rd_chk("scratch", IDX_SCRATCH_RD, 32'ha5c3);
		rd_chk("no side effect", IDX_BUF_STATUS_RD, 32'h0);
		$display("test scratch done");
		// ping-pong half survives a clear request while the async list runs
		apb(1'b1, adr(IDX_BUF_STATUS_WR), 16'h0008);
		core.flip();
		rd_chk("half set", IDX_BUF_STATUS_RD, 32'h0408);
		apb(1'b1, adr(IDX_BUF_STATUS_WR), 16'h0018);
		rd_chk("half kept", IDX_BUF_STATUS_RD, 32'h0418);
		apb(1'b1, adr(IDX_BUF_STATUS_WR), 16'h0000);
		apb(1'b1, adr(IDX_BUF_STATUS_WR), 16'h0010);
		rd_chk("half cleared", IDX_BUF_STATUS_RD, 32'h0010);
		$display("test half done");
		apb(1'b1, adr(IDX_BUF_STATUS_WR), 16'h0013);
		core.read_buf(1'b0);
		core.read_buf(1'b1);
		core.use_buf(1'b1, 1'b0);
		rd_chk("done a in use", IDX_BUF_STATUS_RD, 32'h0333);
		core.use_buf(1'b0, 1'b1);
		rd_chk("done b in use", IDX_BUF_STATUS_RD, 32'h0353);
		apb(1'b1, adr(IDX_BUF_STATUS_WR), 16'h0010);
		apb(1'b1, adr(IDX_BUF_STATUS_WR), 16'h0013);
		rd_chk("done cleared", IDX_BUF_STATUS_RD, 32'h0053);
		apb(1'b1, adr(IDX_BUF_STATUS_WR), 16'hffff);
		rd_chk("status writable", IDX_BUF_STATUS_RD, 32'h005f);
		check("controls", 32'hf, {28'h0, async_list_run_out, periodic_list_run_out, iso_b_full_out, iso_a_full_out});
		core.use_buf(1'b0, 1'b0);
		$display("test status done");
		apb(1'b1, adr(IDX_SOFT_RESET_WR), 16'h00f5);
		rd_chk("scratch kept", IDX_SCRATCH_RD, 32'ha5c3);
		core.flip();
		core.read_buf(1'b0);
		core.raise(10'h3ff);
		apb(1'b1, adr(IDX_SOFT_RESET_WR), 16'h00f6);
		#1;
		check("reset pulse", 32'h1, {31'h0, soft_reset_out});
		check("request cleared", 32'h0, {31'h0, irq_req_out});
		@(posedge mclk_in);
		#1;
		check("reset pulse end", 32'h0, {31'h0, soft_reset_out});
		check("half after reset", 32'h0, {31'h0, paired_entry_half_out});
		rd_chk("mask after reset", IDX_IRQ_MASK_RD, 32'h0);
		rd_chk("scratch after reset", IDX_SCRATCH_RD, 32'h0);
		rd_chk("status after reset", IDX_BUF_STATUS_RD, 32'h0);
		check("pending after reset", 32'h0, {22'h0, irq_pending_out});
		core.raise(10'h000);
		$display("test soft_reset done");
		err_chk(1'b0, adr(8'h30));
		err_chk(1'b1, adr(8'hb2));
		err_chk(1'b1, adr(IDX_SCRATCH_RD));
		err_chk(1'b0, adr(IDX_SCRATCH_RD) | 12'h001);
		err_chk(1'b1, adr(IDX_IDENTITY_RD));
		rd_chk("identity kept", IDX_IDENTITY_RD, {16'h0000, PRODUCT_CODE, REVISION_CODE});
		rd_chk("scratch untouched", IDX_SCRATCH_RD, 32'h0);
		$display("test refusals done");
		tally_and_finish();
	end
endmodule
